// >>> rtl/sps_pin_ctrl.sv
`timescale 1ns/10ps
// Operation
// - MOSI is driven as an output in master role and only sampled in slave role.
// - MISO is sampled in master role and driven in slave role.
// - Data on both lines moves most significant bit first.
// - As master, MOSI always carries the top bit of the shift register.
// - MISO floats when the unit is disabled or is an unselected 4-wire slave.
// - As a 3-wire slave, MISO is always driven from the top shift bit.
// - SCK is generated only in master role and is an input timing the data as slave.
// - A 4-wire slave ignores SCK while its select input is high.
// - Select mode 00 is 3-wire with no select line, and a slave counts as always selected.
// - Select mode 01 makes the select line an input that selects a slave.
// - In mode 01 a falling select input while master drops the master role.
// - With the upper mode bit set, the select line is driven with the lower mode bit.
// - The select line is routed to a pin only in 4-wire modes.
module sps_pin_ctrl
  import sps_pkg::*;
#(
  parameter int DATA_W  = SPS_DATA_WIDTH,
  parameter int SCK_DIV = SPS_SCK_DIV_DEF
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic              enable_i,
  input  wire logic              master_req_i,
  input  wire logic [1:0]        select_mode_field_i,
  input  wire logic              start_i,
  input  wire logic [DATA_W-1:0] tx_data_i,
  output logic      [DATA_W-1:0] rx_data_o,
  output logic                   rx_valid_o,
  output logic                   busy_o,
  output logic                   master_o,
  output logic                   mode_fault_o,
  output logic                   select_routed_o,
  input  wire logic              sck_i,
  output logic                   sck_o,
  output logic                   sck_oe_o,
  input  wire logic              mosi_i,
  output logic                   mosi_o,
  output logic                   mosi_oe_o,
  input  wire logic              miso_i,
  output logic                   miso_o,
  output logic                   miso_oe_o,
  input  wire logic              slave_select_line_i,
  output logic                   slave_select_line_o,
  output logic                   slave_select_line_oe_o
);

  // ------------------------------------------------------------------
  // Pin synchronisation
  // ------------------------------------------------------------------
  sps_sync_if sif ();
  assign sif.sck_raw  = sck_i;
  assign sif.mosi_raw = mosi_i;
  assign sif.miso_raw = miso_i;
  assign sif.sel_raw  = slave_select_line_i;

  sps_sync u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .pins       (sif.sync)
  );

  // ------------------------------------------------------------------
  // Control state
  // ------------------------------------------------------------------
  localparam int CNT_W = $clog2(DATA_W + 1);
  localparam int DIV_W = $clog2(SCK_DIV + 1);

  logic [1:0]        mode_q;
  logic              master_q;
  logic              fault_q;
  logic              sck_s_q;
  logic              sel_s_q;
  logic [DATA_W-1:0] shift_q;
  logic [DATA_W-1:0] rx_q;
  logic              rx_valid_q;
  logic [CNT_W-1:0]  bit_cnt_q;
  logic [DIV_W-1:0]  div_q;
  logic              sck_q;
  logic              in_bit_q;
  sps_state_t        state_q;

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  wire three_wire  = (mode_q == SPS_MODE_3WIRE);
  wire sel_input   = (mode_q == SPS_MODE_4W_SLAVE);
  wire sel_drive   = mode_q[SPS_MODE_HIGH_BIT];
  wire is_slave    = enable_i && !master_q;
  wire is_master   = enable_i && master_q;
  // A slave in 3-wire mode counts as always selected.
  wire selected    = three_wire || !sif.sel_s;
  wire slave_act   = is_slave && selected;
  wire sck_rise    = slave_act && sif.sck_s && !sck_s_q;
  wire sck_fall    = slave_act && !sif.sck_s && sck_s_q;
  wire sel_fall    = sel_input && is_master && sel_s_q && !sif.sel_s;
  wire div_end     = (div_q == DIV_W'(SCK_DIV - 1));
  wire last_bit    = (bit_cnt_q == CNT_W'(DATA_W - 1));
  wire m_sample    = (state_q == SPS_RUN) && div_end && !sck_q;
  wire m_shift     = (state_q == SPS_RUN) && div_end && sck_q;

  // ------------------------------------------------------------------
  // Configuration and role
  // ------------------------------------------------------------------
  // A mode fault drops the master role until software withdraws the request.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_q   <= SPS_MODE_RESET;
      master_q <= 1'b0;
      fault_q  <= 1'b0;
      sck_s_q  <= 1'b0;
      sel_s_q  <= 1'b1;
    end else begin
      mode_q   <= select_mode_field_i;
      sck_s_q  <= sif.sck_s;
      sel_s_q  <= sif.sel_s;
      if (sel_fall) begin
        fault_q  <= 1'b1;
        master_q <= 1'b0;
      end else if (!master_req_i) begin
        fault_q  <= 1'b0;
        master_q <= 1'b0;
      end else if (!fault_q) begin
        master_q <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // Shift engine, eight bits, most significant bit first
  // ------------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q    <= SPS_IDLE;
      shift_q    <= SPS_SHIFT_RESET;
      rx_q       <= SPS_SHIFT_RESET;
      rx_valid_q <= 1'b0;
      bit_cnt_q  <= '0;
      div_q      <= '0;
      sck_q      <= 1'b0;
      in_bit_q   <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      case (state_q)
        SPS_IDLE: begin
          div_q     <= '0;
          sck_q     <= 1'b0;
          if (is_master && start_i) begin
            shift_q   <= tx_data_i;
            bit_cnt_q <= '0;
            state_q   <= SPS_RUN;
          end else if (!slave_act) begin
            // A slave that is deselected or disabled forgets any partial byte.
            bit_cnt_q <= '0;
          end else if (sck_rise) begin
            in_bit_q <= sif.mosi_s;
          end else if (sck_fall) begin
            shift_q   <= {shift_q[DATA_W-2:0], in_bit_q};
            bit_cnt_q <= bit_cnt_q + CNT_W'(1);
            if (last_bit) begin
              rx_q       <= {shift_q[DATA_W-2:0], in_bit_q};
              rx_valid_q <= 1'b1;
              bit_cnt_q  <= '0;
            end
          end
        end
        SPS_RUN: begin
          div_q <= div_end ? '0 : div_q + DIV_W'(1);
          if (!is_master) begin
            bit_cnt_q <= '0;
            state_q   <= SPS_IDLE;
          end else if (m_sample) begin
            sck_q    <= 1'b1;
            in_bit_q <= sif.miso_s;
          end else if (m_shift) begin
            sck_q     <= 1'b0;
            shift_q   <= {shift_q[DATA_W-2:0], in_bit_q};
            bit_cnt_q <= bit_cnt_q + CNT_W'(1);
            if (last_bit) begin
              state_q <= SPS_DONE;
              rx_q    <= {shift_q[DATA_W-2:0], in_bit_q};
            end
          end
        end
        SPS_DONE: begin
          rx_valid_q <= 1'b1;
          bit_cnt_q  <= '0;
          state_q    <= SPS_IDLE;
        end
        default: begin
          state_q <= SPS_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------------
  wire top_bit = shift_q[DATA_W-1];

  assign mosi_o    = top_bit;
  assign mosi_oe_o = is_master;
  assign sck_o     = sck_q;
  assign sck_oe_o  = is_master;
  assign miso_o    = top_bit;
  // Floating MISO when disabled or unselected keeps shared 4-wire buses clean.
  assign miso_oe_o = is_slave && selected;
  assign slave_select_line_o    = mode_q[SPS_MODE_LOW_BIT];
  assign slave_select_line_oe_o = enable_i && sel_drive;
  assign select_routed_o = !three_wire;

  assign rx_data_o    = rx_q;
  assign rx_valid_o   = rx_valid_q;
  assign busy_o       = (state_q != SPS_IDLE);
  assign master_o     = master_q;
  assign mode_fault_o = fault_q;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence sel_drop_s;
    sel_input && is_master && sel_s_q && !sif.sel_s;
  endsequence

  mosi_dir_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    mosi_oe_o == (enable_i && master_q)) else $error("MOSI direction wrong");
  miso_dir_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    master_q |-> !miso_oe_o) else $error("MISO driven as master");
  miso_float_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (!enable_i || (sel_input && sif.sel_s)) |-> !miso_oe_o)
    else $error("MISO not floating");
  miso_3w_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (is_slave && three_wire) |-> (miso_oe_o && miso_o == shift_q[DATA_W-1]))
    else $error("3-wire slave MISO not driven");
  sck_master_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    sck_oe_o |-> master_q) else $error("SCK driven as slave");
  sck_ignore_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (is_slave && sel_input && sif.sel_s && state_q == SPS_IDLE) |=> $stable(shift_q))
    else $error("SCK not ignored");
  master_drop_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    sel_drop_s |=> (!master_q && fault_q)) else $error("master not dropped");
  mode_apply_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $changed(select_mode_field_i) |=> (mode_q == $past(select_mode_field_i)))
    else $error("mode not applied");
  sel_level_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (enable_i && sel_drive) |->
      (slave_select_line_oe_o && slave_select_line_o == mode_q[SPS_MODE_LOW_BIT]))
    else $error("select level wrong");
  sel_route_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (mode_q == SPS_MODE_3WIRE) |-> (!select_routed_o && !slave_select_line_oe_o))
    else $error("select routed in 3-wire");
  rx_done_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (m_shift && last_bit) |=> ##1 rx_valid_o) else $error("no byte after 8 bits");

endmodule : sps_pin_ctrl

// >>> rtl/sps_sync.sv
`timescale 1ns/10ps
module sps_sync
  import sps_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  sps_sync_if.sync  pins
);

  // ------------------------------------------------------------------
  // Two-stage synchronisers for every pin input
  // ------------------------------------------------------------------
  // The first stage is read only by the second stage.
  logic [3:0] meta_q;
  logic [3:0] sync_q;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= SPS_PIN_IDLE;
      sync_q <= SPS_PIN_IDLE;
    end else begin
      meta_q <= {pins.sel_raw, pins.miso_raw, pins.mosi_raw, pins.sck_raw};
      sync_q <= meta_q;
    end
  end

  assign pins.sck_s  = sync_q[0];
  assign pins.mosi_s = sync_q[1];
  assign pins.miso_s = sync_q[2];
  assign pins.sel_s  = sync_q[3];

endmodule : sps_sync

// >>> shared/sps_pkg.sv
package sps_pkg;

  // ------------------------------------------------------------------
  // Slave-select mode encodings
  // ------------------------------------------------------------------
  localparam logic [1:0] SPS_MODE_3WIRE     = 2'h0;
  localparam logic [1:0] SPS_MODE_4W_SLAVE  = 2'h1;
  localparam int         SPS_MODE_HIGH_BIT  = 1;
  localparam int         SPS_MODE_LOW_BIT   = 0;
  localparam logic [1:0] SPS_MODE_RESET     = 2'h0;

  // ------------------------------------------------------------------
  // Transfer shape and timing
  // ------------------------------------------------------------------
  localparam int         SPS_DATA_WIDTH     = 8;
  localparam int         SPS_SYNC_STAGES    = 2;
  localparam int         SPS_CLK_HZ         = 25000000;
  localparam int         SPS_SCK_DIV_DEF    = 4;
  localparam logic [7:0] SPS_SHIFT_RESET    = 8'h00;
  // Synchroniser reset follows the idle pins {select, miso, mosi, sck}, so no false
  // clock edge is seen after reset.
  localparam logic [3:0] SPS_PIN_IDLE       = 4'ha;

  typedef enum logic [1:0] {
    SPS_IDLE  = 2'b00,
    SPS_RUN   = 2'b01,
    SPS_DONE  = 2'b11
  } sps_state_t;

endpackage : sps_pkg

// >>> shared/sps_sync_if.sv
`timescale 1ns/10ps
interface sps_sync_if;
  logic sck_raw;
  logic mosi_raw;
  logic miso_raw;
  logic sel_raw;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic sel_s;
  modport sync (input sck_raw, mosi_raw, miso_raw, sel_raw,
                output sck_s, mosi_s, miso_s, sel_s);
  modport user (output sck_raw, mosi_raw, miso_raw, sel_raw,
                input sck_s, mosi_s, miso_s, sel_s);
endinterface : sps_sync_if

// >>> testbench/sps_far_end.sv
`timescale 1ns/10ps
module sps_far_end (
  input  wire logic sck_i,
  input  wire logic mosi_i,
  output logic      sck_o,
  output logic      mosi_o,
  output logic      miso_o,
  output logic [7:0] got_o
);
  logic [7:0] sh;

  // Slave role: answer from the top bit, move on at each falling clock.
  assign miso_o = sh[7];
  always @(posedge sck_i) got_o = {got_o[6:0], mosi_i};
  always @(negedge sck_i) sh = {sh[6:0], 1'b0};

  task automatic load(input logic [7:0] b);
    sh = b;
  endtask : load

  // Master role: the clock stands low between frames and the data line
  // shows the inverse of its last bit, so no stale value can pass.
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = b[i];
      #160 sck_o = 1'b1;
      #160 sck_o = 1'b0;
    end
    mosi_o = ~b[0];
  endtask : send

  initial begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
    sh = 8'h00;
    got_o = 8'h00;
  end
endmodule : sps_far_end

// >>> testbench/sps_pin_ctrl_tb.sv
`timescale 1ns/10ps
module sps_pin_ctrl_tb;
  import sps_pkg::*;
  logic       core_clk_i = 0, rst_i = 1, en = 0, mreq = 0, start = 0, far_sel_n = 1;
  logic [1:0] mode = 2'h0;
  logic [7:0] tx = 8'h00, rx_data_o;
  logic [31:0] seed = 32'h7a35;
  logic rx_valid_o, busy_o, master_o, mode_fault_o, select_routed_o;
  logic sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o, sel_o, sel_oe_o;
  logic far_sck, far_mosi, far_miso;
  logic [7:0] far_got;
  logic [7:0] exp_q[$];
  int   err_count = 0, n_tests = 0;
  wire  sck_w  = sck_oe_o ? sck_o : far_sck;
  wire  mosi_w = mosi_oe_o ? mosi_o : far_mosi;
  wire  miso_w = miso_oe_o ? miso_o : far_miso;
  wire  sel_w  = sel_oe_o ? sel_o : far_sel_n;

  always #20 core_clk_i = ~core_clk_i;

  sps_pin_ctrl i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .enable_i(en),
    .master_req_i(mreq), .select_mode_field_i(mode), .start_i(start), .tx_data_i(tx),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .busy_o(busy_o), .master_o(master_o),
    .mode_fault_o(mode_fault_o), .select_routed_o(select_routed_o), .sck_i(sck_w),
    .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_o(mosi_oe_o), .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
    .slave_select_line_i(sel_w), .slave_select_line_o(sel_o),
    .slave_select_line_oe_o(sel_oe_o));

  sps_far_end i_far (.sck_i(sck_w), .mosi_i(mosi_w), .sck_o(far_sck), .mosi_o(far_mosi),
    .miso_o(far_miso), .got_o(far_got));

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude

  // A byte that nobody expected is a mismatch on its own.
  always @(negedge core_clk_i) if (rx_valid_o === 1'b1) begin
    if (exp_q.size() == 0) chk(8'h01, 8'h00);
    else chk(rx_data_o, exp_q.pop_front());
  end

  task automatic drain();
    for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge core_clk_i);
    chk(8'(exp_q.size()), 8'h00);
    exp_q.delete();
  endtask : drain

  task automatic mbyte();
    logic [7:0] a, b;
    a = rnd();
    b = rnd();
    i_far.load(b);
    exp_q.push_back(b);
    @(posedge core_clk_i) begin
      start <= 1'b1;
      tx <= a;
    end
    @(posedge core_clk_i) start <= 1'b0;
    @(negedge core_clk_i) chk(8'(busy_o), 8'h01);
    drain();
    chk(8'(busy_o), 8'h00);
    chk(far_got, a);
  endtask : mbyte

  task automatic sbyte(input bit expect_byte);
    logic [7:0] b;
    b = rnd();
    if (expect_byte) exp_q.push_back(b);
    i_far.send(b);
    repeat (8) @(posedge core_clk_i);
    drain();
    @(negedge core_clk_i);
    if (expect_byte) chk(8'(miso_o), 8'(b[7]));
  endtask : sbyte

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : settle

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    settle(1);
    chk(8'({sck_oe_o, mosi_oe_o, miso_oe_o, sel_oe_o, select_routed_o}), 8'h00);
    @(posedge core_clk_i) begin
      en <= 1'b1;
      mreq <= 1'b1;
    end
    for (int m = 0; m < 4; m++) begin
      @(posedge core_clk_i) mode <= 2'(m);
      settle(3);
      chk(8'({master_o, sck_oe_o, mosi_oe_o, miso_oe_o, select_routed_o}),
          {4'h1, 3'h6, 1'(m != 0)});
      chk(8'({sel_oe_o, sel_oe_o & sel_o}), 8'({1'(m > 1), 1'(m == 3)}));
      mbyte();
    end
    @(posedge core_clk_i) mode <= SPS_MODE_4W_SLAVE;
    settle(4);
    @(posedge core_clk_i) far_sel_n <= 1'b0;
    settle(6);
    chk(8'({master_o, mode_fault_o}), 8'h01);
    @(posedge core_clk_i) begin
      mreq <= 1'b0;
      far_sel_n <= 1'b1;
    end
    settle(4);
    chk(8'({mode_fault_o, miso_oe_o}), 8'h00);
    sbyte(1'b0);
    @(posedge core_clk_i) far_sel_n <= 1'b0;
    settle(4);
    chk(8'(miso_oe_o), 8'h01);
    sbyte(1'b1);
    sbyte(1'b1);
    @(posedge core_clk_i) begin
      far_sel_n <= 1'b1;
      mode <= SPS_MODE_3WIRE;
    end
    settle(4);
    chk(8'({sck_oe_o, mosi_oe_o, miso_oe_o}), 8'h01);
    sbyte(1'b1);
    @(posedge core_clk_i) en <= 1'b0;
    settle(3);
    chk(8'(miso_oe_o), 8'h00);
    conclude();
  end

  initial begin
    #200000;
    err_count++;
    conclude();
  end
endmodule : sps_pin_ctrl_tb
